// [logic/esi_pkg.sv]
package esi_pkg;

    // instruction code points
    localparam logic [7:0] ESI_OP_XFER_MAX   = 8'h7F;
    localparam logic [7:0] ESI_OP_COMMIT     = 8'h80;
    localparam logic [7:0] ESI_OP_CAL_ALL    = 8'h90;
    localparam logic [7:0] ESI_OP_CAL_SYS    = 8'h91;
    localparam logic [7:0] ESI_OP_CAL_APA    = 8'h92;
    localparam logic [7:0] ESI_OP_CAL_APB    = 8'h93;
    localparam logic [7:0] ESI_OP_FREE_BOTH  = 8'h98;
    localparam logic [7:0] ESI_OP_FREE_A     = 8'h99;
    localparam logic [7:0] ESI_OP_FREE_B     = 8'h9A;
    localparam logic [7:0] ESI_OP_SYNC_ALL   = 8'hA0;
    localparam logic [7:0] ESI_OP_SYNC_CH0   = 8'hA1;
    localparam logic [7:0] ESI_OP_SYNC_CH1   = 8'hA2;
    localparam logic [7:0] ESI_OP_COND_BASE  = 8'hB0;
    localparam logic [3:0] ESI_OP_COND_HI    = 4'hB;
    localparam logic [7:0] ESI_OP_PAUSE      = 8'hFE;
    localparam logic [7:0] ESI_OP_END        = 8'hFF;

    // register map offsets (Avalon word addresses, byte address = 4 * index)
    localparam logic [3:0] ESI_REG_CTRL      = 4'h0;
    localparam logic [3:0] ESI_REG_STATUS    = 4'h1;
    localparam logic [3:0] ESI_REG_CMAP      = 4'h2;
    localparam logic [3:0] ESI_REG_PTR       = 4'h3;

    // control register fields
    localparam int         ESI_CTRL_COND_LSB = 0;
    localparam int         ESI_CTRL_COND_W   = 4;
    localparam logic [3:0] ESI_CTRL_RST      = 4'h0;

    localparam logic [31:0] ESI_UNMAPPED_RD  = 32'h0000_0000;

    typedef enum logic [2:0]
    {
        ESI_ST_IDLE  = 3'b000,
        ESI_ST_OP    = 3'b001,
        ESI_ST_ADDRH = 3'b010,
        ESI_ST_ADDRL = 3'b011,
        ESI_ST_DATA  = 3'b100
    } esi_state_t;

    typedef enum logic [0:0]
    {
        ESI_DIR_DOWN = 1'b0,
        ESI_DIR_UP   = 1'b1
    } esi_dir_t;

endpackage

// [logic/esi_interp.sv]
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - every instruction is one byte, optionally followed by payload bytes
// - download consumes stored instruction bytes strictly in order
// - upload emits instruction bytes from sequence registers plus fetched data
// - codes 00..7F are register transfers with two-byte address, MSB first
// - a transfer moves code plus one data bytes from the start address
// - 80 stored on upload, fires commit strobe on download
// - 90..AF stored on upload, acted upon only on download
// - 90..93 request PLL calibrations on download
// - 98..9A force digital loops to freerun on download
// - A0..A2 synchronise distribution outputs on download
// - FE is a pause in upload
// - FF ends the sequence in both directions
// - B0..BF stored verbatim on upload, no effect on upload flow
// - condition value is the code minus B0, range 0..15
// - software gives a 4-bit condition id compared with the map
// - nonzero condition value is added to the map on download
// - condition value zero empties the map on download
// - conditional and end codes always execute on download
// - empty map or id zero lets every instruction run
// - nonzero id present in the map lets instructions run
// - otherwise instructions are skipped until a matching or zero condition
// - pause idles but keeps the memory address pointer
// - end clears pointer; upload stores checksum, download verifies it
module esi_interp
    import esi_pkg::*;
#(
    parameter int PTR_W = 16
)
(
    input  wire logic        mclk_in,
    input  wire logic        nrst_in,
    // byte stream in: memory bytes on download, sequence bytes on upload
    input  wire logic        start_in,
    input  wire logic        dir_up_in,
    input  wire logic [7:0]  byte_in,
    input  wire logic        byte_valid_in,
    output logic             byte_ready_out,
    // register data fetched for an upload transfer
    input  wire logic [7:0]  fetch_data_in,
    // byte stream out: register writes on download, memory writes on upload
    output logic [7:0]       reg_data_out,
    output logic [15:0]      reg_addr_out,
    output logic             reg_wr_out,
    output logic             reg_rd_out,
    output logic [7:0]       mem_data_out,
    output logic             mem_wr_out,
    output logic             crc_store_out,
    output logic             crc_check_out,
    // device actions, one-cycle pulses; then busy, paused and pointer status levels
    output logic             commit_out,
    output logic             cal_sys_pll_out,
    output logic             cal_analog_output_pll_a_out,
    output logic             cal_analog_output_pll_b_out,
    output logic             freerun_digital_loop_a_out,
    output logic             freerun_digital_loop_b_out,
    output logic             sync_ch0_out,
    output logic             sync_ch1_out,
    output logic             busy_out,
    output logic             paused_out,
    output logic [PTR_W-1:0] mem_ptr_out,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);

    // readback word and pointer increment both assume this width range
    if (PTR_W < 8 || PTR_W > 32)
    begin
        $error("esi_interp: PTR_W out of range");
    end

    // count_q holds the payload bytes still to move, minus one
    esi_state_t       state_q;
    esi_dir_t         dir_q;
    logic [6:0]       count_q;
    logic [15:0]      addr_q;
    logic [15:0]      cmap_q;
    logic [3:0]       cond_id_q;
    logic [PTR_W-1:0] ptr_q;
    logic             paused_q;
    logic             skip_q;
    logic             ack_q;

    // stream and condition decode, all combinational
    logic             take;
    logic             is_cond;
    logic [3:0]       cval;
    logic             run_ok;
    logic             down_q_run;

    assign take    = byte_valid_in && byte_ready_out;
    assign is_cond = (byte_in[7:4] == ESI_OP_COND_HI);
    assign cval    = 4'(byte_in - ESI_OP_COND_BASE);
    assign run_ok  = (cmap_q == 16'h0000) || (cond_id_q == 4'h0) || cmap_q[cond_id_q];
    assign down_q_run = (dir_q == ESI_DIR_DOWN) && run_ok;
    // an upload fetch cycle must not swallow the next sequence byte
    always_comb
    begin
        byte_ready_out = (state_q != ESI_ST_IDLE);
        if (dir_q == ESI_DIR_UP && state_q == ESI_ST_DATA)
            byte_ready_out = 1'b0;
    end
    assign busy_out    = (state_q != ESI_ST_IDLE);
    assign paused_out  = paused_q;
    assign mem_ptr_out = ptr_q;

    // sequencer: one byte per take, payload counted down
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_q  <= ESI_ST_IDLE;
            dir_q    <= ESI_DIR_DOWN;
            count_q  <= 7'h00;
            addr_q   <= 16'h0000;
            skip_q   <= 1'b0;
            paused_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ESI_ST_IDLE:
                begin
                    if (start_in)
                    begin
                        state_q  <= ESI_ST_OP;
                        dir_q    <= esi_dir_t'(dir_up_in);
                        paused_q <= 1'b0;
                    end
                end
                ESI_ST_OP:
                begin
                    if (take)
                    begin
                        if (byte_in <= ESI_OP_XFER_MAX)
                        begin
                            count_q <= byte_in[6:0];
                            // decision frozen at the opcode, payload still consumed
                            skip_q  <= (dir_q == ESI_DIR_DOWN) && !run_ok;
                            state_q <= ESI_ST_ADDRH;
                        end
                        else if (byte_in == ESI_OP_END)
                            state_q <= ESI_ST_IDLE;
                        // a pause on download falls through as a no-op
                        else if (byte_in == ESI_OP_PAUSE && dir_q == ESI_DIR_UP)
                        begin
                            state_q  <= ESI_ST_IDLE;
                            paused_q <= 1'b1;
                        end
                    end
                end
                ESI_ST_ADDRH:
                begin
                    if (take)
                    begin
                        addr_q[15:8] <= byte_in;
                        state_q      <= ESI_ST_ADDRL;
                    end
                end
                ESI_ST_ADDRL:
                begin
                    if (take)
                    begin
                        addr_q[7:0] <= byte_in;
                        state_q     <= ESI_ST_DATA;
                    end
                end
                ESI_ST_DATA:
                begin
                    // upload fetches one register byte per cycle, no stream byte used
                    if (take || dir_q == ESI_DIR_UP)
                    begin
                        addr_q <= addr_q + 16'h0001;
                        if (count_q == 7'h00)
                            state_q <= ESI_ST_OP;
                        else
                            count_q <= count_q - 7'h01;
                    end
                end
                default:
                    state_q <= ESI_ST_IDLE;
            endcase
        end
    end

    // memory address pointer survives a pause, cleared at end
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            ptr_q <= '0;
        else if (state_q == ESI_ST_OP && take && byte_in == ESI_OP_END)
            ptr_q <= '0;
        // the end byte's own store lands a cycle later and must not bump the pointer
        else if (crc_store_out || crc_check_out)
            ptr_q <= '0;
        // download counts taken bytes, upload counts stored bytes
        else if (mem_wr_out || (dir_q == ESI_DIR_DOWN && take))
            ptr_q <= ptr_q + PTR_W'(1);
    end

    // condition map, cleared at a start that is not a resume, set by condition codes only on download
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            cmap_q <= 16'h0000;
        // a resumed upload keeps the map of the interrupted run
        else if (state_q == ESI_ST_IDLE && start_in && !paused_q)
            cmap_q <= 16'h0000;
        else if (state_q == ESI_ST_OP && take && is_cond && dir_q == ESI_DIR_DOWN)
        begin
            if (cval == 4'h0)
                cmap_q <= 16'h0000;
            else
                cmap_q[cval] <= 1'b1;
        end
    end

    // register-side and memory-side byte strobes
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            reg_data_out  <= 8'h00;
            reg_addr_out  <= 16'h0000;
            reg_wr_out    <= 1'b0;
            reg_rd_out    <= 1'b0;
            mem_data_out  <= 8'h00;
            mem_wr_out    <= 1'b0;
            crc_store_out <= 1'b0;
            crc_check_out <= 1'b0;
        end
        else
        begin
            reg_wr_out    <= 1'b0;
            reg_rd_out    <= 1'b0;
            mem_wr_out    <= 1'b0;
            crc_store_out <= 1'b0;
            crc_check_out <= 1'b0;
            if (dir_q == ESI_DIR_DOWN && state_q == ESI_ST_DATA && take && !skip_q)
            begin
                reg_data_out <= byte_in;
                reg_addr_out <= addr_q;
                reg_wr_out   <= 1'b1;
            end
            if (dir_q == ESI_DIR_UP && state_q == ESI_ST_DATA)
            begin
                // fetched register byte lands in the image
                reg_addr_out <= addr_q;
                reg_rd_out   <= 1'b1;
                mem_data_out <= fetch_data_in;
                mem_wr_out   <= 1'b1;
            end
            else if (dir_q == ESI_DIR_UP && take && state_q != ESI_ST_IDLE
                     && !(state_q == ESI_ST_OP && byte_in == ESI_OP_PAUSE))
            begin
                // codes stored verbatim, incl. conditional and reserved ones
                mem_data_out <= byte_in;
                mem_wr_out   <= 1'b1;
            end
            // checksum work itself is left to the serial side
            if (state_q == ESI_ST_OP && take && byte_in == ESI_OP_END)
            begin
                crc_store_out <= (dir_q == ESI_DIR_UP);
                crc_check_out <= (dir_q == ESI_DIR_DOWN);
            end
        end
    end

    // device action pulses; unlisted codes fall through as no-ops
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            commit_out                  <= 1'b0;
            cal_sys_pll_out             <= 1'b0;
            cal_analog_output_pll_a_out <= 1'b0;
            cal_analog_output_pll_b_out <= 1'b0;
            freerun_digital_loop_a_out  <= 1'b0;
            freerun_digital_loop_b_out  <= 1'b0;
            sync_ch0_out                <= 1'b0;
            sync_ch1_out                <= 1'b0;
        end
        else
        begin
            commit_out                  <= 1'b0;
            cal_sys_pll_out             <= 1'b0;
            cal_analog_output_pll_a_out <= 1'b0;
            cal_analog_output_pll_b_out <= 1'b0;
            freerun_digital_loop_a_out  <= 1'b0;
            freerun_digital_loop_b_out  <= 1'b0;
            sync_ch0_out                <= 1'b0;
            sync_ch1_out                <= 1'b0;
            if (state_q == ESI_ST_OP && take && down_q_run)
            begin
                case (byte_in)
                    ESI_OP_COMMIT:    commit_out <= 1'b1;
                    ESI_OP_CAL_ALL:
                    begin
                        cal_sys_pll_out             <= 1'b1;
                        cal_analog_output_pll_a_out <= 1'b1;
                        cal_analog_output_pll_b_out <= 1'b1;
                    end
                    ESI_OP_CAL_SYS:   cal_sys_pll_out <= 1'b1;
                    ESI_OP_CAL_APA:   cal_analog_output_pll_a_out <= 1'b1;
                    ESI_OP_CAL_APB:   cal_analog_output_pll_b_out <= 1'b1;
                    ESI_OP_FREE_BOTH:
                    begin
                        freerun_digital_loop_a_out <= 1'b1;
                        freerun_digital_loop_b_out <= 1'b1;
                    end
                    ESI_OP_FREE_A:    freerun_digital_loop_a_out <= 1'b1;
                    ESI_OP_FREE_B:    freerun_digital_loop_b_out <= 1'b1;
                    ESI_OP_SYNC_ALL:
                    begin
                        sync_ch0_out <= 1'b1;
                        sync_ch1_out <= 1'b1;
                    end
                    ESI_OP_SYNC_CH0:  sync_ch0_out <= 1'b1;
                    ESI_OP_SYNC_CH1:  sync_ch1_out <= 1'b1;
                    default:          ;
                endcase
            end
        end
    end

    // Avalon slave: one wait cycle, then acknowledge
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            ack_q <= 1'b0;
        else
            // toggling gives one wait cycle per access, back to back too
            ack_q <= (avs_read || avs_write) && !ack_q;
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            cond_id_q <= ESI_CTRL_RST;
        // written on the completing edge, the one the master samples
        else if (avs_write && ack_q && avs_address == ESI_REG_CTRL)
            cond_id_q <= avs_writedata[ESI_CTRL_COND_LSB +: ESI_CTRL_COND_W];
    end

    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            avs_readdata <= 32'h0000_0000;
        // loaded in the wait cycle so it stands at the completing edge
        else if (avs_read && !ack_q)
        begin
            case (avs_address)
                ESI_REG_CTRL:   avs_readdata <= {28'h0, cond_id_q};
                ESI_REG_STATUS: avs_readdata <= {27'h0, skip_q, paused_q, dir_q, state_q != ESI_ST_IDLE, !run_ok};
                ESI_REG_CMAP:   avs_readdata <= {16'h0, cmap_q};
                ESI_REG_PTR:    avs_readdata <= 32'(ptr_q);
                default:        avs_readdata <= ESI_UNMAPPED_RD;
            endcase
        end
    end

endmodule

// [test/esi_interp_chk.sv]
`timescale 1ns/1ps
module esi_interp_chk
    import esi_pkg::*;
#(
    parameter int PTR_W = 16
)
(
    input wire logic             mclk_in,
    input wire logic             nrst_in,
    input wire logic             start_in,
    input wire logic             dir_up_in,
    input wire logic [7:0]       byte_in,
    input wire logic             byte_valid_in,
    input wire logic             byte_ready_out,
    input wire logic             busy_out,
    input wire logic             paused_out,
    input wire logic             reg_wr_out,
    input wire logic             mem_wr_out,
    input wire logic             crc_store_out,
    input wire logic             crc_check_out,
    input wire logic             commit_out,
    input wire logic             cal_analog_output_pll_a_out,
    input wire logic             freerun_digital_loop_a_out,
    input wire logic             sync_ch1_out,
    input wire logic [PTR_W-1:0] mem_ptr_out,
    input wire logic             avs_read,
    input wire logic             avs_write,
    input wire logic             avs_waitrequest
);
    logic up_q;
    logic tk;
    assign tk = byte_valid_in && byte_ready_out;
    // direction is only latched where the design samples it
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            up_q <= 1'b0;
        else if (start_in && !busy_out)
            up_q <= dir_up_in;
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    act_only_down_a: assert property (up_q |-> !(commit_out || cal_analog_output_pll_a_out || sync_ch1_out))
        else $error("action pulse during upload");
    mem_only_up_a: assert property (!up_q |-> !mem_wr_out && !crc_store_out)
        else $error("memory write during download");
    reg_wr_down_a: assert property (reg_wr_out |-> !up_q)
        else $error("register write during upload");
    commit_code_a: assert property (commit_out |-> $past(tk) && $past(byte_in) == 8'h80)
        else $error("commit without its code");
    cal_code_a: assert property (cal_analog_output_pll_a_out |-> $past(tk) && $past(byte_in) inside {8'h90, 8'h92})
        else $error("calibration without its code");
    free_code_a: assert property (freerun_digital_loop_a_out |-> $past(byte_in) inside {8'h98, 8'h99})
        else $error("freerun without its code");
    sync_code_a: assert property (sync_ch1_out |-> $past(byte_in) inside {8'hA0, 8'hA2})
        else $error("sync without its code");
    end_ptr_a: assert property (crc_check_out || crc_store_out |-> ##[0:2] mem_ptr_out == '0)
        else $error("pointer not cleared at end");
    pause_idle_a: assert property ($rose(paused_out) |-> up_q && !busy_out && $past(byte_in) == 8'hFE)
        else $error("pause entered wrongly");
    wait_one_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one cycle");
    ready_busy_a: assert property (byte_ready_out |-> busy_out)
        else $error("stream ready outside a sequence");
    ready_down_a: assert property (busy_out && !up_q |-> byte_ready_out)
        else $error("download not taking bytes");
endmodule
bind esi_interp esi_interp_chk #(.PTR_W(PTR_W)) u_chk (.mclk_in, .nrst_in, .start_in, .dir_up_in, .byte_in,
    .byte_valid_in, .byte_ready_out, .busy_out, .paused_out, .reg_wr_out, .mem_wr_out, .crc_store_out,
    .crc_check_out, .commit_out, .cal_analog_output_pll_a_out, .freerun_digital_loop_a_out, .sync_ch1_out,
    .mem_ptr_out, .avs_read, .avs_write, .avs_waitrequest);

// [test/esi_mem_model.sv]
`timescale 1ns/1ps
module esi_mem_model
(
    input  wire logic       mclk_in,
    input  wire logic       nrst_in,
    input  wire logic       ready_in,
    input  wire logic       stall_in,
    output logic      [7:0] byte_out,
    output logic            valid_out
);
    logic [7:0] img [0:63];
    logic [5:0] rd_q;
    logic [7:0] last_q;
    assign valid_out = nrst_in && ready_in && !stall_in;
    // released line shows the inverse of the last byte, never a stale copy
    assign byte_out = valid_out ? img[rd_q] : ~last_q;
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rd_q   <= 6'h00;
            last_q <= 8'h00;
        end
        else if (valid_out)
        begin
            rd_q   <= rd_q + 6'h01;
            last_q <= img[rd_q];
        end
    end
endmodule

// [test/test_esi_interp.sv]
`timescale 1ns/1ps
module test_esi_interp;
    import esi_pkg::*;
    logic        mclk_in, nrst_in, start_in, dir_up_in, stall, valid_w, ready_w, reg_wr, mem_wr, crc_st, crc_ck;
    logic        busy, paused, avs_read, avs_write, avs_waitrequest, reg_rd;
    logic [7:0]  byte_w, fetch, fetch_q, reg_data, mem_data, act;
    logic [15:0] reg_addr, ptr;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic [33:0] ev;
    logic [33:0] exq [$];
    logic [7:0]  acode [11] = '{8'h80, 8'h90, 8'h91, 8'h92, 8'h93, 8'h98, 8'h99, 8'h9A, 8'hA0, 8'hA1, 8'hA2};
    logic [7:0]  aexp [11]  = '{8'h80, 8'h70, 8'h40, 8'h20, 8'h10, 8'h0C, 8'h08, 8'h04, 8'h03, 8'h02, 8'h01};
    int          err_total, check_count, cyc, nimg, st_n, ck_n, i;
    esi_interp uut (.mclk_in(mclk_in), .nrst_in(nrst_in), .start_in(start_in), .dir_up_in(dir_up_in),
        .byte_in(byte_w), .byte_valid_in(valid_w), .byte_ready_out(ready_w), .fetch_data_in(fetch),
        .reg_data_out(reg_data), .reg_addr_out(reg_addr), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
        .mem_data_out(mem_data),
        .mem_wr_out(mem_wr), .crc_store_out(crc_st), .crc_check_out(crc_ck), .commit_out(act[7]),
        .cal_sys_pll_out(act[6]), .cal_analog_output_pll_a_out(act[5]), .cal_analog_output_pll_b_out(act[4]),
        .freerun_digital_loop_a_out(act[3]), .freerun_digital_loop_b_out(act[2]), .sync_ch0_out(act[1]),
        .sync_ch1_out(act[0]), .busy_out(busy), .paused_out(paused), .mem_ptr_out(ptr), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    esi_mem_model u_mem (.mclk_in(mclk_in), .nrst_in(nrst_in), .ready_in(ready_w), .stall_in(stall),
        .byte_out(byte_w), .valid_out(valid_w));
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] wd, input logic [31:0] e);
        @(posedge mclk_in);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge mclk_in); while (avs_waitrequest !== 1'b0);
        if (!w)
            chk({2'b00, avs_readdata}, {2'b00, e});
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic put(input logic [7:0] b);
        u_mem.img[nimg] = b;
        nimg++;
    endtask
    task automatic pm(input logic [7:0] b);
        put(b);
        exq.push_back({8'h00, 2'b01, b, 16'h0000});
    endtask
    task automatic run(input logic up);
        @(posedge mclk_in);
        start_in <= 1'b1;
        dir_up_in <= up;
        @(posedge mclk_in);
        start_in <= 1'b0;
        do @(negedge mclk_in); while (busy !== 1'b0);
        repeat (3) @(posedge mclk_in);
        chk(34'(exq.size()), 34'd0);
    endtask
    // results are sampled mid-cycle, where the registered pulses have settled
    always @(negedge mclk_in)
    begin
        if (crc_st === 1'b1) st_n++;
        if (crc_ck === 1'b1) ck_n++;
        if ((|act) !== 1'b0 || reg_wr !== 1'b0 || mem_wr !== 1'b0 || reg_rd !== 1'b0)
        begin
            // a fetched byte must equal the register data presented at its edge
            ev = {act, reg_wr, mem_wr,
                  reg_wr ? reg_data : (reg_rd ? mem_data ^ fetch_q : (mem_wr ? mem_data : 8'h00)),
                  (reg_wr || reg_rd) ? reg_addr : 16'h0000};
            if (exq.size() == 0)
                chk(ev, 34'h0);
            else
                chk(ev, exq.pop_front());
        end
    end
    initial
    begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in)
    begin
        stall <= ($urandom % 4) == 0;
        fetch_q <= fetch;
        fetch <= 8'($urandom);
        cyc++;
        if (cyc > 20000)
        begin
            err_total++;
            test_done();
        end
    end
    initial
    begin
        {nrst_in, start_in, dir_up_in, avs_read, avs_write} = 5'h00;
        {avs_address, avs_writedata} = 36'h0;
        void'($urandom(32'h19DD36D0));
        repeat (3) @(posedge mclk_in);
        nrst_in <= 1'b1;
        avs(1'b1, ESI_REG_CTRL, 32'h1, 32'h0);
        avs(1'b0, ESI_REG_CTRL, 32'h0, 32'h1);
        avs(1'b1, 4'h9, 32'h5A, 32'h0);
        avs(1'b0, 4'h9, 32'h0, ESI_UNMAPPED_RD);
        d = $urandom;
        put(8'h01); put(8'h12); put(8'h34); put(d[7:0]); put(d[15:8]);
        exq.push_back({8'h00, 2'b10, d[7:0], 16'h1234});
        exq.push_back({8'h00, 2'b10, d[15:8], 16'h1235});
        for (i = 0; i < 11; i++)
        begin
            put(acode[i]);
            exq.push_back({aexp[i], 2'b00, 8'h00, 16'h0000});
        end
        put(8'h85); put(8'hFE);
        put(8'hB2); put(8'h00); put(8'hAA); put(8'hBB); put(8'hCC); put(8'h80);
        put(8'hB1); put(8'h00); put(8'h00); put(8'h05); put(d[23:16]);
        exq.push_back({8'h00, 2'b10, d[23:16], 16'h0005});
        put(8'hB0); put(8'h91); put(8'hFF);
        exq.push_back({8'h40, 2'b00, 8'h00, 16'h0000});
        run(1'b0);
        chk(34'(ck_n), 34'd1);
        avs(1'b0, ESI_REG_PTR, 32'h0, 32'h0);
        avs(1'b1, ESI_REG_CTRL, 32'h0, 32'h0);
        put(8'hB3); put(8'h80); put(8'hB5); put(8'hFF);
        exq.push_back({8'h80, 2'b00, 8'h00, 16'h0000});
        run(1'b0);
        avs(1'b0, ESI_REG_CMAP, 32'h0, 32'h28);
        pm(8'h80); pm(8'hB3); pm(8'h91); put(8'hFE);
        run(1'b1);
        chk({33'h0, paused}, 34'd1);
        chk({33'h0, ptr !== 16'h0000}, 34'd1);
        pm(8'h85);
        pm(8'h01);
        pm(8'h20);
        pm(8'h40);
        exq.push_back({8'h00, 2'b01, 8'h00, 16'h2040});
        exq.push_back({8'h00, 2'b01, 8'h00, 16'h2041});
        pm(8'hFF);
        run(1'b1);
        chk(34'(st_n), 34'd1);
        chk({18'h0, ptr}, 34'h0);
        test_done();
    end
endmodule
